// ==== pkg/timer_e_regs.vh ====
/*
 register offsets, reset values, field positions and prescaler bit positions
 for the timer e square wave unit. included by the apb register block.
*/
`ifndef TIMER_E_REGS_VH
`define TIMER_E_REGS_VH
`define OFS_MODE 12'h000
`define OFS_COUNT 12'h004
`define OFS_PIN_MODE 12'h008
`define OFS_IRQ_CTRL 12'h00c
`define RST_MODE 8'h78
`define RST_COUNT 8'h00
`define RST_RELOAD 8'h00
`define RST_PIN_MODE 8'h0f
`define MODE_RSVD 8'h78
`define PIN_RSVD 8'h0f
`define BIT_RELOAD_MODE 7
`define BIT_OUT_SEL 7
`define BIT_OUT_ON 6
`define BIT_FIXED_RATE 5
`define BIT_VAR_RATE 4
`define BIT_FLAG 0
`define BIT_ENABLE 1
`define BIT_EXT_SEL 2
`define PRESCALE_W 13
`define FIXED_SLOW_BIT 10
`define FIXED_FAST_BIT 9
`endif

// ==== verilog/timer_e_square_wave_unit.v ====
/*
 timer e square wave unit: 8-bit prescaled up-counter, interval and
 auto-reload modes, overflow flag with enable, square wave pin logic.
 assumes an apb master on pclk; the pin input arrives asynchronously.
*/
// Decided for this implementation: the placing of the registers and register access over APB.
// Overview of operation
// - pin mode register resets to 0x0f, upper four control bits clear.
// - low four pin mode bits read as ones, writes ignored.
// - external interrupt select 1 makes the pin an interrupt input.
// - both selects zero leave the pin as general-purpose port bit.
// - fixed wave is clock/2048, or clock/1024 with fixed-rate bit.
// - variable mode toggles the pin level at each counter overflow.
// - square wave has equal high and low times in both modes.
// - reload mode bit zero runs counter as free interval timer.
// - after reset counter is zero, interval mode, counting at once.
// - counter advances on one of eight prescaler taps.
// - overflow after 0xff sets flag; interrupt only when enabled.
// - interval mode wraps the counter to zero at overflow.
// - interval mode reload write also loads the counter.
// - reload mode loads reload value into counter at overflow.
// - reload mode write of reload value initialises the counter.
// - reload period is 256 minus reload value input pulses.
// - flag stays set on acceptance; software clears it.
// - toggle output period is two overflow periods.
// - clock codes 0..7 select 8192,4096,2048,512,256,128,32,8.
// - counter read and reload write share one address.
// - mode register resets to interval, slowest clock, ones reserved.
`timescale 1ns/1ps
`include "timer_e_regs.vh"

module timer_e_square_wave_unit (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire port1_bit5_in,
  input wire port1_bit5_out_data,
  input wire port1_bit5_dir_out,
  output reg timer_wave_out_pin_o,
  output reg timer_wave_out_pin_oe_n,
  output reg external_interrupt_pin_level,
  output reg irq_o
);

  reg [7:0] mode_ff;
  reg [7:0] count_ff;
  reg [7:0] reload_ff;
  reg [3:0] pin_mode_ff;
  reg flag_ff;
  reg enable_ff;
  reg ext_sel_ff;
  reg [`PRESCALE_W-1:0] prescale_ff;
  reg [`PRESCALE_W-1:0] prescale_q_ff;
  reg toggle_ff;
  reg pin_sync1_ff;
  reg pin_sync2_ff;

  reg [7:0] nxt_count;
  reg nxt_flag;
  reg nxt_toggle;
  reg [31:0] nxt_prdata;
  reg nxt_pin;
  reg nxt_oe_n;
  reg [7:0] nxt_mode;
  reg [7:0] nxt_reload;
  reg [3:0] nxt_pin_mode;
  reg nxt_enable;
  reg nxt_ext_sel;
  reg nxt_pready;
  reg nxt_pslverr;
  reg nxt_ext_level;
  reg nxt_irq;
  reg sel_mode;
  reg sel_count;
  reg sel_pin;
  reg sel_ctrl;
  wire [`PRESCALE_W-1:0] bit_rise;

  // only the upper nibble of the pin mode register is storage
  localparam [7:0] PIN_MODE_RESET = `RST_PIN_MODE;

  wire access = psel & penable;
  // writes act on the first access edge only, not again while ready
  wire wr = access & pwrite & ~pready;

  // address decode shared by read and write paths
  function addr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  // tap bit whose rising edge marks one divided clock period
  function [3:0] tap_bit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: tap_bit = 4'hc;
        3'h1: tap_bit = 4'hb;
        3'h2: tap_bit = 4'ha;
        3'h3: tap_bit = 4'h8;
        3'h4: tap_bit = 4'h7;
        3'h5: tap_bit = 4'h6;
        3'h6: tap_bit = 4'h4;
        default: tap_bit = 4'h2;
      endcase
    end
  endfunction

  // address decode for both paths; the chain keeps it one-hot
  always @* begin
    sel_mode = 1'b0;
    sel_count = 1'b0;
    sel_pin = 1'b0;
    sel_ctrl = 1'b0;
    if (addr_hit(paddr, `OFS_MODE)) begin
      sel_mode = 1'b1;
    end else if (addr_hit(paddr, `OFS_COUNT)) begin
      sel_count = 1'b1;
    end else if (addr_hit(paddr, `OFS_PIN_MODE)) begin
      sel_pin = 1'b1;
    end else if (addr_hit(paddr, `OFS_IRQ_CTRL)) begin
      sel_ctrl = 1'b1;
    end
  end

  // one rising-edge detector per divider bit
  genvar k;
  generate
    for (k = 0; k < `PRESCALE_W; k = k + 1) begin : g_rise
      assign bit_rise[k] = prescale_ff[k] & ~prescale_q_ff[k];
    end
  endgenerate

  wire [3:0] tap = tap_bit(mode_ff[2:0]);
  // rising edge of a divider bit: one pulse per 2^(tap+1) clocks
  wire tick = bit_rise[tap];
  wire ovf = tick & (count_ff == 8'hff);
  wire reload_mode = mode_ff[`BIT_RELOAD_MODE];
  wire reload_wr = wr & sel_count;
  wire out_sel = pin_mode_ff[`BIT_OUT_SEL-4];
  wire out_on = pin_mode_ff[`BIT_OUT_ON-4];
  wire fixed_fast = pin_mode_ff[`BIT_FIXED_RATE-4];
  wire var_rate = pin_mode_ff[`BIT_VAR_RATE-4];
  wire flag_clr = wr & sel_ctrl & ~pwdata[`BIT_FLAG];
  wire mapped = sel_mode | sel_count | sel_pin | sel_ctrl;

  // free-running prescaler, never stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_ff <= {`PRESCALE_W{1'b0}};
      prescale_q_ff <= {`PRESCALE_W{1'b0}};
    end else begin
      prescale_ff <= prescale_ff + {{(`PRESCALE_W-1){1'b0}}, 1'b1};
      prescale_q_ff <= prescale_ff;
    end
  end

  always @* begin
    nxt_count = count_ff;
    if (reload_wr) begin
      nxt_count = pwdata[7:0];
    end else if (ovf) begin
      if (reload_mode) begin
        nxt_count = reload_ff;
      end else begin
        nxt_count = 8'h00;
      end
    end else if (tick) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  // a set in the same cycle as a clear wins
  always @* begin
    nxt_flag = flag_ff;
    if (flag_clr) begin
      nxt_flag = 1'b0;
    end
    if (ovf) begin
      nxt_flag = 1'b1;
    end
  end

  always @* begin
    nxt_toggle = toggle_ff;
    if (!(out_sel && out_on)) begin
      nxt_toggle = 1'b0;
    end else if (ovf) begin
      nxt_toggle = ~toggle_ff;
    end
  end

  // pin function; the interrupt select overrides everything
  always @* begin
    nxt_pin = 1'b0;
    nxt_oe_n = 1'b1;
    if (ext_sel_ff) begin
      nxt_oe_n = 1'b1;
    end else if (!out_sel) begin
      nxt_pin = port1_bit5_out_data;
      nxt_oe_n = ~port1_bit5_dir_out;
    end else if (!out_on) begin
      nxt_oe_n = 1'b0;
    end else if (var_rate) begin
      nxt_pin = toggle_ff;
      nxt_oe_n = 1'b0;
    end else begin
      // a single divider bit is a 50% wave by construction
      nxt_oe_n = 1'b0;
      if (fixed_fast) begin
        nxt_pin = prescale_ff[`FIXED_FAST_BIT];
      end else begin
        nxt_pin = prescale_ff[`FIXED_SLOW_BIT];
      end
    end
  end

  always @* begin
    nxt_prdata = 32'h00000000;
    if (sel_mode) begin
      nxt_prdata[7:0] = mode_ff | `MODE_RSVD;
    end else if (sel_count) begin
      nxt_prdata[7:0] = count_ff;
    end else if (sel_pin) begin
      nxt_prdata[7:0] = {pin_mode_ff, 4'h0} | `PIN_RSVD;
    end else if (sel_ctrl) begin
      nxt_prdata[2:0] = {ext_sel_ff, enable_ff, flag_ff};
    end
  end

  // reserved bits are rebuilt here, never stored from the bus
  always @* begin
    nxt_mode = mode_ff;
    nxt_reload = reload_ff;
    nxt_pin_mode = pin_mode_ff;
    nxt_enable = enable_ff;
    nxt_ext_sel = ext_sel_ff;
    if (wr) begin
      if (sel_mode) begin
        nxt_mode = {pwdata[7], 4'h0, pwdata[2:0]} | `MODE_RSVD;
      end else if (sel_count) begin
        nxt_reload = pwdata[7:0];
      end else if (sel_pin) begin
        nxt_pin_mode = pwdata[7:4];
      end else if (sel_ctrl) begin
        nxt_enable = pwdata[`BIT_ENABLE];
        nxt_ext_sel = pwdata[`BIT_EXT_SEL];
      end
    end
  end

  // one wait state: setup, access, ready in the following cycle
  always @* begin
    nxt_pready = access & ~pready;
    nxt_pslverr = access & ~pready & ~mapped;
    // interrupt pin level only when the pin is in that role
    nxt_ext_level = ext_sel_ff & pin_sync2_ff;
    nxt_irq = nxt_flag & enable_ff;
  end

  // first count comes on the first rise of the selected tap after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= `RST_COUNT;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_ff <= 1'b0;
    end else begin
      toggle_ff <= nxt_toggle;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= `RST_MODE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_ff <= `RST_RELOAD;
    end else begin
      reload_ff <= nxt_reload;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode_ff <= PIN_MODE_RESET[7:4];
    end else begin
      pin_mode_ff <= nxt_pin_mode;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= 1'b0;
      ext_sel_ff <= 1'b0;
    end else begin
      enable_ff <= nxt_enable;
      ext_sel_ff <= nxt_ext_sel;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= nxt_prdata;
      pready <= nxt_pready;
      pslverr <= nxt_pslverr;
    end
  end

  // only the second flop feeds logic; the first may go metastable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1_ff <= 1'b0;
      pin_sync2_ff <= 1'b0;
    end else begin
      pin_sync1_ff <= port1_bit5_in;
      pin_sync2_ff <= pin_sync1_ff;
    end
  end

  // pin released after reset until software picks a role
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_wave_out_pin_o <= 1'b0;
      timer_wave_out_pin_oe_n <= 1'b1;
    end else begin
      timer_wave_out_pin_o <= nxt_pin;
      timer_wave_out_pin_oe_n <= nxt_oe_n;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_interrupt_pin_level <= 1'b0;
    end else begin
      external_interrupt_pin_level <= nxt_ext_level;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= nxt_irq;
    end
  end

endmodule // timer_e_square_wave_unit

// ==== dv/timer_e_square_wave_unit_properties.sv ====
/* port assertions for the timer e square wave unit.
 bound to the design; sees its ports only. */
`timescale 1ns/1ps
module timer_e_square_wave_unit_properties (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire timer_wave_out_pin_oe_n,
  input wire external_interrupt_pin_level,
  input wire irq_o
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && !pwrite && pready;
  wire bad = paddr > 12'h00c || paddr[1:0] != 2'b00;
  wire ctl_wr = psel && pwrite && paddr == 12'h00c;
  sequence s_take; psel && penable && !pready; endsequence
  sequence s_done; pready ##1 !pready; endsequence
  property p_answer; s_take |=> s_done; endproperty
  property p_err; pready |-> pslverr == bad; endproperty
  property p_err_zero; rd && pslverr |-> prdata == 0; endproperty
  property p_upper; rd |-> prdata[31:8] == 0; endproperty
  property p_pin_rsvd; rd && paddr == 12'h008 |-> prdata[3:0] == 4'hf;
  endproperty
  property p_mode_rsvd; rd && paddr == 0 |-> prdata[6:3] == 4'hf;
  endproperty
  // flag is sticky, so irq only drops after a control write
  property p_clear; $fell(irq_o) |-> $past(ctl_wr, 2); endproperty
  property p_ext_in;
    external_interrupt_pin_level |-> timer_wave_out_pin_oe_n;
  endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  a_err: assert property (p_err) else $error("bad slverr");
  a_err_zero: assert property (p_err_zero) else $error("nonzero");
  a_upper: assert property (p_upper) else $error("upper bits");
  a_pin_rsvd: assert property (p_pin_rsvd) else $error("pin low");
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode");
  a_clear: assert property (p_clear) else $error("irq dropped");
  a_ext_in: assert property (p_ext_in) else $error("pin driven");
endmodule // timer_e_square_wave_unit_properties
bind timer_e_square_wave_unit
  timer_e_square_wave_unit_properties u_props (.*);

// ==== dv/test_timer_e_square_wave_unit.sv ====
/* self-checking bench for the timer e square wave unit.
 assumes the design on a 50 MHz pclk, apb driven here. */
`timescale 1ns/1ps
module test_timer_e_square_wave_unit;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rv, r;
  reg pin_in = 0, pdat = 0, pdir = 0, se, lv;
  reg [7:0] dd;
  wire [31:0] prdata;
  wire pready, pslverr, wo, woe_n, ext, irq;
  integer seed = 44, err_total = 0, tests_run = 0, cyc = 0, i, h, a, b;
  always #10 pclk = ~pclk;
  timer_e_square_wave_unit DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port1_bit5_in(pin_in),
    .port1_bit5_out_data(pdat), .port1_bit5_dir_out(pdir),
    .timer_wave_out_pin_o(wo), .timer_wave_out_pin_oe_n(woe_n),
    .external_interrupt_pin_level(ext), .irq_o(irq));
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [11:0] ad, input [31:0] d);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  // cycles until the wave pin changes level
  task run_len(output integer n);
    begin
      lv = wo;
      n = 0;
      while (wo === lv && n < 5000) begin
        @(posedge pclk);
        n = n + 1;
      end
    end
  endtask
  function integer dv(input [2:0] c);
    dv = c == 0 ? 8192 : c == 1 ? 4096 : c == 2 ? 2048 : c == 3 ? 512 :
      c == 4 ? 256 : c == 5 ? 128 : c == 6 ? 32 : 8;
  endfunction
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 4; i = i + 1) begin
      apb(0, {i[9:0], 2'b00}, 0);
      chk(rv, i == 0 ? 32'h78 : i == 2 ? 32'h0f : 0);
    end
    apb(0, 12'h010, 0);
    chk({rv[30:0], se}, 1);
    for (i = 0; i < 2; i = i + 1) begin
      r = $random(seed);
      apb(1, 12'h000, {i[0], 7'h00});
      apb(1, 12'h004, r);
      apb(0, 12'h004, 0);
      dd = rv[7:0] - r[7:0];
      chk(dd < 2, 1);
    end
    r = $random(seed);
    apb(1, 12'h008, r);
    apb(0, 12'h008, 0);
    chk(rv, {r[7:4], 4'hf});
    apb(1, 12'h000, r);
    apb(0, 12'h000, 0);
    chk(rv, {r[7], 4'hf, r[2:0]});
    // free-running prescaler phase allows one tick either way
    for (i = 0; i < 8; i = i + 1) begin
      apb(1, 12'h000, i);
      apb(1, 12'h004, 0);
      repeat (4 * dv(i[2:0])) @(posedge pclk);
      apb(0, 12'h004, 0);
      chk(rv > 2 && rv < 6, 1);
    end
    apb(1, 12'h00c, 2);
    apb(1, 12'h004, 8'hfe);
    repeat (32) @(posedge pclk);
    chk(irq, 1);
    apb(0, 12'h004, 0);
    chk(rv < 8'h10, 1);
    apb(1, 12'h00c, 0);
    apb(1, 12'h004, 8'hff);
    repeat (24) @(posedge pclk);
    apb(0, 12'h00c, 0);
    chk({irq, rv[1:0]}, 3'b001);
    apb(1, 12'h008, 8'h80);
    repeat (3) @(posedge pclk);
    chk({wo, woe_n}, 0);
    r = $random(seed) | 32'hc0;
    apb(1, 12'h000, 8'h87);
    apb(1, 12'h004, r);
    for (i = 0; i < 3; i = i + 1) begin
      apb(1, 12'h008, i == 0 ? 8'hc0 : i == 1 ? 8'he0 : 8'hd0);
      run_len(a);
      run_len(a);
      run_len(b);
      h = i == 0 ? 1024 : i == 1 ? 512 : (256 - r[7:0]) * 8;
      chk({a[30:0], woe_n}, {h[30:0], 1'b0});
      chk(b, h);
    end
    // leave the toggle high, switch off, reload far away, switch on
    while (wo !== 1'b1) @(posedge pclk);
    apb(1, 12'h008, 8'h80);
    apb(1, 12'h004, 0);
    apb(1, 12'h008, 8'hd0);
    repeat (3) @(posedge pclk);
    chk({wo, woe_n}, 0);
    apb(1, 12'h008, 0);
    pdir <= 1;
    pdat <= r[0];
    repeat (3) @(posedge pclk);
    chk({wo, woe_n}, {r[0], 1'b0});
    pdir <= 0;
    apb(1, 12'h00c, 4);
    apb(1, 12'h008, 8'hd0);
    pin_in <= 1;
    repeat (5) @(posedge pclk);
    chk({ext, woe_n}, 2'b11);
    complete_run;
  end
endmodule // test_timer_e_square_wave_unit
